// >>> hw/dlpb_defines.vh
// register offsets, field layouts, reset values and limits of the drive limit parameter bank
// assumes a plain register port with 16-bit data and one clock
// Functional notes
// [R1] switching-frequency select 0, 1 and 2 decode to 4, 8 and 16 kHz, and 1 is the default.
// [R2] a new switching-frequency select is stored but reaches the power stage only after a logic supply restart.
// [R3] a switching frequency other than the factory one lowers the power stage nominal and peak currents.
// [R4] the brake-resistor-controller flag reads 0 when absent and 1 when present, defaults to 0, and software sets it when one is attached.
// [R5] the parameter-set selector picks set one with 1 and set two with 2, 0 has no effect, and the default is 1.
// [R6] each set's current limit, 100 counts per ampere peak, applies in every mode except manual and quick stop.
// [R7] the quick-stop current limit replaces the set limit during a quick stop.
// [R8] the manual current limit bounds motor current in manual movement mode.
// [R9] every current limit is bounded above by the lower of motor peak current and power stage peak current.
// [R10] each input and output state bit reads 1 for 24 V (active) and 0 for 0 V.
// [R11] input states are reported as two words and output states as two words.
// [R12] an interface-mode setting selects fixed or freely assignable pin mapping.
// [R13] with forcing enabled, input and output states follow the forced values, not the pins.
// [R14] a write outside a parameter's range is rejected and the old value kept.
`ifndef DLPB_DEFINES_VH
`define DLPB_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DLPB_ADDR_W 5
`define DLPB_OFS_SET1_ILIM 5'h00
`define DLPB_OFS_SET2_ILIM 5'h01
`define DLPB_OFS_SET1_NLIM 5'h02
`define DLPB_OFS_SET2_NLIM 5'h03
`define DLPB_OFS_PSET 5'h04
`define DLPB_OFS_QS_ILIM 5'h05
`define DLPB_OFS_MAN_ILIM 5'h06
`define DLPB_OFS_BRC 5'h07
`define DLPB_OFS_FCHOP 5'h08
`define DLPB_OFS_FCHOP_ACT 5'h09
`define DLPB_OFS_IN_A 5'h0a
`define DLPB_OFS_IN_B 5'h0b
`define DLPB_OFS_OUT_A 5'h0c
`define DLPB_OFS_OUT_B 5'h0d
`define DLPB_OFS_IO_MODE 5'h0e
`define DLPB_OFS_FORCE_CTL 5'h0f
`define DLPB_OFS_FORCE_IN_A 5'h10
`define DLPB_OFS_FORCE_IN_B 5'h11
`define DLPB_OFS_FORCE_OUT_A 5'h12
`define DLPB_OFS_FORCE_OUT_B 5'h13
`define DLPB_OFS_ACT_ILIM 5'h14
`define DLPB_OFS_ACT_NLIM 5'h15
`define DLPB_OFS_PA_CUR 5'h16

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define DLPB_PSET_RST 16'h0001
`define DLPB_PSET_ONE 16'h0001
`define DLPB_PSET_TWO 16'h0002
`define DLPB_BRC_RST 16'h0000
`define DLPB_BRC_MAX 16'h0001
`define DLPB_FCHOP_RST 2'h1
`define DLPB_FCHOP_4K 2'h0
`define DLPB_FCHOP_8K 2'h1
`define DLPB_FCHOP_16K 2'h2
`define DLPB_FCHOP_FACTORY 2'h1
`define DLPB_ILIM_RST 16'h0000
`define DLPB_NLIM_RST 16'h0000

// ----------------------------------------
// force control bit positions
// ----------------------------------------
`define DLPB_FORCE_IN_A_BIT 0
`define DLPB_FORCE_IN_B_BIT 1
`define DLPB_FORCE_OUT_A_BIT 2
`define DLPB_FORCE_OUT_B_BIT 3

// ----------------------------------------
// power stage derating, in sixteenths
// ----------------------------------------
`define DLPB_DERATE_NONE 5'h10
`define DLPB_DERATE_4K 5'h0c
`define DLPB_DERATE_8K 5'h0c
`define DLPB_DERATE_16K 5'h08
`endif

// >>> hw/dlpb_sync16.v
// two-flop synchroniser for a 16-bit group of pin levels
// assumes each bit is an independent slow level from a pin
`timescale 1ns/1ps
`default_nettype none
module dlpb_sync16 (
	input wire clk, // system clock
	input wire rst, // synchronous reset
	input wire [15:0] pin_in, // asynchronous pin levels
	output wire [15:0] pin_sync // synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			always @(posedge clk) begin
				if (rst) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else begin
					meta <= pin_in[i];
					stable <= meta;
				end
			end
			assign pin_sync[i] = stable;
		end
	endgenerate
endmodule // dlpb_sync16
`default_nettype wire

// >>> hw/dlpb_fchop.v
// switching-frequency select holder: stored value and the value live on the power stage
// assumes logic_restart pulses once when the logic supply comes back
`timescale 1ns/1ps
`default_nettype none
`include "dlpb_defines.vh"
module dlpb_fchop (
	input wire clk, // system clock
	input wire rst, // synchronous reset
	input wire wr_en, // accepted write of the select
	input wire [1:0] wr_val, // written select
	input wire logic_restart, // logic supply restart pulse
	output reg [1:0] fchop_stored, // stored select
	output reg [1:0] fchop_active, // select driving the power stage
	output reg [2:0] fchop_onehot // 4k, 8k, 16k decode of active select
);
	always @(posedge clk) begin
		if (rst) begin
			fchop_stored <= `DLPB_FCHOP_RST;
			fchop_active <= `DLPB_FCHOP_RST;
		end else begin
			if (wr_en)
				fchop_stored <= wr_val;
			// [R2] apply on restart
			if (logic_restart)
				fchop_active <= wr_en ? wr_val : fchop_stored;
		end
	end

	// [R1] frequency decode
	always @(posedge clk) begin
		if (rst) begin
			fchop_onehot <= 3'h2;
		end else begin
			case (fchop_active)
				`DLPB_FCHOP_4K: fchop_onehot <= 3'h1;
				`DLPB_FCHOP_8K: fchop_onehot <= 3'h2;
				`DLPB_FCHOP_16K: fchop_onehot <= 3'h4;
				default: fchop_onehot <= 3'h2;
			endcase
		end
	end
endmodule // dlpb_fchop
`default_nettype wire

// >>> hw/dlpb_bank.v
// drive limit parameter bank: limits, set selector, chopper select, i/o state words
// assumes motor and power stage ratings arrive from same-clock logic; i/o pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "dlpb_defines.vh"
module dlpb_bank (
	input wire clk, // system clock
	input wire rst, // synchronous reset
	input wire [4:0] addr, // register address
	input wire [15:0] wdata, // write data
	input wire wr, // write strobe
	input wire rd, // read strobe
	output reg [15:0] rdata, // read data, cycle after rd
	input wire logic_restart, // logic supply restart pulse
	input wire quick_stop, // quick stop in progress
	input wire manual_mode, // manual movement mode
	input wire [15:0] motor_peak_current, // motor peak current, 100 per apk
	input wire [15:0] motor_top_speed, // motor top speed, rpm
	input wire [15:0] pa_nominal_rated, // factory power stage nominal current
	input wire [15:0] pa_peak_rated, // factory power stage peak current
	input wire [15:0] in_pins_a, // input pin levels, word a
	input wire [15:0] in_pins_b, // input pin levels, word b
	input wire [15:0] out_logic_a, // output levels from logic, word a
	input wire [15:0] out_logic_b, // output levels from logic, word b
	output reg [15:0] input_state_word_a, // effective inputs word a
	output reg [15:0] input_state_word_b, // effective inputs word b
	output reg [15:0] output_state_word_a, // driven outputs word a
	output reg [15:0] output_state_word_b, // driven outputs word b
	output reg io_free_mapping, // 1 free, 0 fixed pin mapping
	output reg [15:0] active_current_limit, // enforced current limit
	output reg [15:0] active_speed_limit, // enforced speed limit
	output reg [15:0] power_stage_nominal_current, // derated nominal current
	output reg [15:0] power_stage_peak_current, // derated peak current
	output reg brake_resistor_ctrl_present, // external controller attached
	output wire [2:0] fchop_onehot, // active 4k, 8k, 16k select
	output reg set_two_active // parameter set two in use
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	// limits reset to 0, so nothing can drive until software sets them
	reg [15:0] set1_current_limit;
	reg [15:0] set2_current_limit;
	reg [15:0] set1_speed_limit;
	reg [15:0] set2_speed_limit;
	reg [15:0] parameter_set_select;
	reg [15:0] quick_stop_current_limit;
	reg [15:0] manual_current_limit;
	reg [3:0] force_ctl;
	reg [15:0] force_in_a;
	reg [15:0] force_in_b;
	reg [15:0] force_out_a;
	reg [15:0] force_out_b;
	wire [1:0] fchop_stored;
	wire [1:0] fchop_active;
	wire [15:0] in_sync_a;
	wire [15:0] in_sync_b;
	reg [15:0] cur_max;
	reg [4:0] derate;
	reg [20:0] nom_scaled;
	reg [20:0] peak_scaled;
	reg [15:0] next_rdata;
	reg ilim_ok;
	reg nlim_ok;
	reg fchop_ok;
	reg [15:0] sel_current_limit;
	reg [15:0] next_current_limit;
	wire fchop_wr;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// pins are asynchronous; only the second flop of each bit is read
	dlpb_sync16 u_sync_a (
		.clk(clk),
		.rst(rst),
		.pin_in(in_pins_a),
		.pin_sync(in_sync_a)
	);
	dlpb_sync16 u_sync_b (
		.clk(clk),
		.rst(rst),
		.pin_in(in_pins_b),
		.pin_sync(in_sync_b)
	);

	// ----------------------------------------
	// power stage derating and current ceiling
	// ----------------------------------------
	// [R3] derate off factory
	// the fraction is in sixteenths, so a 16-bit rating fits the 20-bit product
	always @* begin
		case (fchop_active)
			`DLPB_FCHOP_4K: derate = `DLPB_DERATE_4K;
			`DLPB_FCHOP_8K: derate = `DLPB_DERATE_8K;
			`DLPB_FCHOP_16K: derate = `DLPB_DERATE_16K;
			default: derate = `DLPB_DERATE_NONE;
		endcase
		// any select other than the factory one runs derated
		if (fchop_active == `DLPB_FCHOP_FACTORY)
			derate = `DLPB_DERATE_NONE;
		nom_scaled = pa_nominal_rated * derate;
		peak_scaled = pa_peak_rated * derate;
	end

	always @(posedge clk) begin
		if (rst) begin
			power_stage_nominal_current <= 16'h0000;
			power_stage_peak_current <= 16'h0000;
		end else begin
			power_stage_nominal_current <= nom_scaled[19:4];
			power_stage_peak_current <= peak_scaled[19:4];
		end
	end

	// ----------------------------------------
	// current ceiling
	// ----------------------------------------
	// [R9] lower of two peaks
	always @* begin
		if (motor_peak_current < power_stage_peak_current)
			cur_max = motor_peak_current;
		else
			cur_max = power_stage_peak_current;
	end

	// ----------------------------------------
	// write range checks
	// ----------------------------------------
	// [R14] range gates
	always @* begin
		ilim_ok = (wdata <= cur_max);
		nlim_ok = (wdata <= motor_top_speed);
		fchop_ok = (wdata <= {14'h0000, `DLPB_FCHOP_16K});
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			set1_current_limit <= `DLPB_ILIM_RST;
			set2_current_limit <= `DLPB_ILIM_RST;
			set1_speed_limit <= `DLPB_NLIM_RST;
			set2_speed_limit <= `DLPB_NLIM_RST;
			parameter_set_select <= `DLPB_PSET_RST;
			quick_stop_current_limit <= `DLPB_ILIM_RST;
			manual_current_limit <= `DLPB_ILIM_RST;
			brake_resistor_ctrl_present <= 1'b0;
			io_free_mapping <= 1'b0;
			force_ctl <= 4'h0;
			force_in_a <= 16'h0000;
			force_in_b <= 16'h0000;
			force_out_a <= 16'h0000;
			force_out_b <= 16'h0000;
		end else if (wr) begin
			case (addr)
				`DLPB_OFS_SET1_ILIM: if (ilim_ok) set1_current_limit <= wdata;
				`DLPB_OFS_SET2_ILIM: if (ilim_ok) set2_current_limit <= wdata;
				`DLPB_OFS_SET1_NLIM: if (nlim_ok) set1_speed_limit <= wdata;
				`DLPB_OFS_SET2_NLIM: if (nlim_ok) set2_speed_limit <= wdata;
				// [R5] 0 accepted, no effect
				`DLPB_OFS_PSET: if (wdata <= `DLPB_PSET_TWO) parameter_set_select <= wdata;
				`DLPB_OFS_QS_ILIM: if (ilim_ok) quick_stop_current_limit <= wdata;
				`DLPB_OFS_MAN_ILIM: if (ilim_ok) manual_current_limit <= wdata;
				// [R4] flag 0 or 1
				`DLPB_OFS_BRC: if (wdata <= `DLPB_BRC_MAX) brake_resistor_ctrl_present <= wdata[0];
				// [R12] mapping mode
				`DLPB_OFS_IO_MODE: io_free_mapping <= wdata[0];
				`DLPB_OFS_FORCE_CTL: force_ctl <= wdata[3:0];
				`DLPB_OFS_FORCE_IN_A: force_in_a <= wdata;
				`DLPB_OFS_FORCE_IN_B: force_in_b <= wdata;
				`DLPB_OFS_FORCE_OUT_A: force_out_a <= wdata;
				`DLPB_OFS_FORCE_OUT_B: force_out_b <= wdata;
				// read-only and unmapped offsets drop the write
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// chopper select
	// ----------------------------------------
	// the stored select reads back at once; the live one moves only on a restart
	assign fchop_wr = wr && (addr == `DLPB_OFS_FCHOP) && fchop_ok;

	dlpb_fchop u_fchop (
		.clk(clk),
		.rst(rst),
		.wr_en(fchop_wr),
		.wr_val(wdata[1:0]),
		.logic_restart(logic_restart),
		.fchop_stored(fchop_stored),
		.fchop_active(fchop_active),
		.fchop_onehot(fchop_onehot)
	);

	// ----------------------------------------
	// active limit selection
	// ----------------------------------------
	// stored limits are range checked only when written, and a restart to a non-factory
	// chopper can drop the ceiling under them, so the enforced limit is clamped too
	always @* begin
		// [R7] quick stop first
		if (quick_stop)
			sel_current_limit = quick_stop_current_limit;
		// [R8] manual limit
		else if (manual_mode)
			sel_current_limit = manual_current_limit;
		// [R6] per-set limit
		else if (set_two_active)
			sel_current_limit = set2_current_limit;
		else
			sel_current_limit = set1_current_limit;
		// [R9] clamp to ceiling
		if (sel_current_limit > cur_max)
			next_current_limit = cur_max;
		else
			next_current_limit = sel_current_limit;
	end

	always @(posedge clk) begin
		if (rst) begin
			set_two_active <= 1'b0;
			active_current_limit <= 16'h0000;
			active_speed_limit <= 16'h0000;
		end else begin
			// [R5] select set; 0 holds previous
			if (parameter_set_select == `DLPB_PSET_ONE)
				set_two_active <= 1'b0;
			else if (parameter_set_select == `DLPB_PSET_TWO)
				set_two_active <= 1'b1;
			active_current_limit <= next_current_limit;
			active_speed_limit <= set_two_active ? set2_speed_limit : set1_speed_limit;
		end
	end

	// ----------------------------------------
	// signal interface state words
	// ----------------------------------------
	// bits read 1 for 24 V; force words override pins per whole word
	always @(posedge clk) begin
		if (rst) begin
			input_state_word_a <= 16'h0000;
			input_state_word_b <= 16'h0000;
			output_state_word_a <= 16'h0000;
			output_state_word_b <= 16'h0000;
		end else begin
			// [R10] active high levels
			// [R13] forced values win
			input_state_word_a <= force_ctl[`DLPB_FORCE_IN_A_BIT] ? force_in_a : in_sync_a;
			input_state_word_b <= force_ctl[`DLPB_FORCE_IN_B_BIT] ? force_in_b : in_sync_b;
			output_state_word_a <= force_ctl[`DLPB_FORCE_OUT_A_BIT] ? force_out_a : out_logic_a;
			output_state_word_b <= force_ctl[`DLPB_FORCE_OUT_B_BIT] ? force_out_b : out_logic_b;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always @* begin
		case (addr)
			`DLPB_OFS_SET1_ILIM: next_rdata = set1_current_limit;
			`DLPB_OFS_SET2_ILIM: next_rdata = set2_current_limit;
			`DLPB_OFS_SET1_NLIM: next_rdata = set1_speed_limit;
			`DLPB_OFS_SET2_NLIM: next_rdata = set2_speed_limit;
			`DLPB_OFS_PSET: next_rdata = parameter_set_select;
			`DLPB_OFS_QS_ILIM: next_rdata = quick_stop_current_limit;
			`DLPB_OFS_MAN_ILIM: next_rdata = manual_current_limit;
			`DLPB_OFS_BRC: next_rdata = {15'h0000, brake_resistor_ctrl_present};
			`DLPB_OFS_FCHOP: next_rdata = {14'h0000, fchop_stored};
			`DLPB_OFS_FCHOP_ACT: next_rdata = {14'h0000, fchop_active};
			// [R11] two input, two output words
			`DLPB_OFS_IN_A: next_rdata = input_state_word_a;
			`DLPB_OFS_IN_B: next_rdata = input_state_word_b;
			`DLPB_OFS_OUT_A: next_rdata = output_state_word_a;
			`DLPB_OFS_OUT_B: next_rdata = output_state_word_b;
			`DLPB_OFS_IO_MODE: next_rdata = {15'h0000, io_free_mapping};
			`DLPB_OFS_FORCE_CTL: next_rdata = {12'h000, force_ctl};
			`DLPB_OFS_FORCE_IN_A: next_rdata = force_in_a;
			`DLPB_OFS_FORCE_IN_B: next_rdata = force_in_b;
			`DLPB_OFS_FORCE_OUT_A: next_rdata = force_out_a;
			`DLPB_OFS_FORCE_OUT_B: next_rdata = force_out_b;
			`DLPB_OFS_ACT_ILIM: next_rdata = active_current_limit;
			`DLPB_OFS_ACT_NLIM: next_rdata = active_speed_limit;
			`DLPB_OFS_PA_CUR: next_rdata = power_stage_peak_current;
			default: next_rdata = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// read data register
	// ----------------------------------------
	// data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rst)
			rdata <= 16'h0000;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 16'h0000;
	end
endmodule // dlpb_bank
`default_nettype wire

// >>> tb/dlpb_bank_monitor.sv
// checker for the drive limit parameter bank: chopper decode, selector, flags, derating
// assumes it is bound to dlpb_bank and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module dlpb_bank_monitor (
	input wire logic clk, // clock
	input wire logic rst, // sync reset
	input wire logic [4:0] addr, // address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [15:0] rdata, // read data
	input wire logic logic_restart, // restart pulse
	input wire logic [15:0] pa_peak_rated, // rated peak
	input wire logic io_free_mapping, // mapping mode
	input wire logic [15:0] power_stage_peak_current, // derated peak
	input wire logic brake_resistor_ctrl_present, // brake flag
	input wire logic [2:0] fchop_onehot, // chopper decode
	input wire logic set_two_active // set two in use
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// --------------------------------
	// assertions
	// --------------------------------
	a_chop_reset_8k: assert property ($past(rst) |-> fchop_onehot == 3'b010)
		else $error("chopper decode not 8 kHz after reset");
	a_chop_one_hot: assert property ($onehot(fchop_onehot))
		else $error("chopper decode not one-hot");
	a_chop_restart_only: assert property ($changed(fchop_onehot)
		|-> $past(logic_restart) || $past(logic_restart, 2))
		else $error("chopper changed without restart");
	a_select_set_two: assert property ((wr && addr == 5'h04 && wdata == 16'h0002)
		|=> ##1 set_two_active)
		else $error("select 2 did not pick set two");
	a_select_set_one: assert property ((wr && addr == 5'h04 && wdata == 16'h0001)
		|=> ##1 !set_two_active)
		else $error("select 1 did not pick set one");
	a_brake_flag_set: assert property ((wr && addr == 5'h07 && wdata == 16'h0001)
		|-> ##[1:2] brake_resistor_ctrl_present)
		else $error("brake flag not set");
	a_io_mode_free: assert property ((wr && addr == 5'h0e && wdata[0])
		|-> ##[1:2] io_free_mapping)
		else $error("free mapping not selected");
	a_read_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside read answer");
	a_derate_16k_peak: assert property ((fchop_onehot[2] && $stable(fchop_onehot)
		&& $stable(pa_peak_rated)) |-> power_stage_peak_current == (pa_peak_rated >> 1))
		else $error("peak current not derated at 16 kHz");
	// --------------------------------
	// cover points
	// --------------------------------
	c_restart_16k: cover property (logic_restart ##2 fchop_onehot[2]);
	c_select_two: cover property (wr && addr == 5'h04 && wdata == 16'h0002);
	c_read_data: cover property (rd ##1 rdata != 16'h0000);
endmodule // dlpb_bank_monitor

bind dlpb_bank dlpb_bank_monitor dlpb_bank_monitor_inst (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .logic_restart(logic_restart),
	.pa_peak_rated(pa_peak_rated), .io_free_mapping(io_free_mapping),
	.power_stage_peak_current(power_stage_peak_current),
	.brake_resistor_ctrl_present(brake_resistor_ctrl_present),
	.fchop_onehot(fchop_onehot), .set_two_active(set_two_active));
`default_nettype wire

// >>> tb/dlpb_bank_tb_top.sv
// self-checking bench for the drive limit parameter bank against a register model
// assumes dlpb_bank alone; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module dlpb_bank_tb_top;
	logic clk, rst, wr, rd, rs, qs, man;
	logic [4:0] addr;
	logic [15:0] wdata, mpk, mns, pnom, ppk, pa, pb, oa, ob;
	wire [15:0] rdata, iwa, iwb, owa, owb, acl, asl, psn, psp;
	wire iom, brc, s2;
	wire [2:0] oh;
	logic [15:0] m [0:31];
	logic [1:0] fca;
	int errors, samples_checked, sel, seed, i, a, d;
	dlpb_bank dlpb_bank_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .logic_restart(rs), .quick_stop(qs), .manual_mode(man),
		.motor_peak_current(mpk), .motor_top_speed(mns), .pa_nominal_rated(pnom),
		.pa_peak_rated(ppk), .in_pins_a(pa), .in_pins_b(pb), .out_logic_a(oa), .out_logic_b(ob),
		.input_state_word_a(iwa), .input_state_word_b(iwb), .output_state_word_a(owa),
		.output_state_word_b(owb), .io_free_mapping(iom), .active_current_limit(acl),
		.active_speed_limit(asl), .power_stage_nominal_current(psn),
		.power_stage_peak_current(psp), .brake_resistor_ctrl_present(brc), .fchop_onehot(oh),
		.set_two_active(s2));
	// --------------------------------
	// reference model
	// --------------------------------
	// factory select full rating, 16 kHz half, 4 kHz three quarters
	function automatic logic [15:0] der(input logic [15:0] r);
		return (fca == 2'h1) ? r : ((fca == 2'h2) ? (r >> 1) : 16'((32'(r) * 12) >> 4));
	endfunction
	function automatic logic [15:0] ilim_max();
		return (mpk < der(ppk)) ? mpk : der(ppk);
	endfunction
	function automatic logic [15:0] exp_acl();
		logic [15:0] s;
		s = qs ? m[5] : (man ? m[6] : ((sel == 2) ? m[1] : m[0]));
		return (s > ilim_max()) ? ilim_max() : s;
	endfunction
	function automatic logic [15:0] exp_rd(input int x);
		case (x)
			9: return {14'h0, fca};
			10: return m[15][0] ? m[16] : pa;
			11: return m[15][1] ? m[17] : pb;
			12: return m[15][2] ? m[18] : oa;
			13: return m[15][3] ? m[19] : ob;
			20: return exp_acl();
			21: return (sel == 2) ? m[3] : m[2];
			22: return der(ppk);
			default: return (x < 20) ? m[x] : 16'h0;
		endcase
	endfunction
	// --------------------------------
	// bus and check tasks
	// --------------------------------
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr_reg(input int x, input logic [15:0] v);
		logic ok;
		case (x)
			0, 1, 5, 6: ok = v <= ilim_max();
			2, 3: ok = v <= mns;
			4, 8: ok = v <= 2;
			7: ok = v <= 1;
			9, 10, 11, 12, 13, 20, 21, 22: ok = 0;
			default: ok = 1;
		endcase
		if (ok) m[x] = (x == 14) ? {15'h0, v[0]} : ((x == 15) ? {12'h0, v[3:0]} : v);
		if (ok && x == 4 && v != 0) sel = v;
		@(posedge clk);
		{addr, wdata, wr} <= {x[4:0], v, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input int x);
		@(posedge clk);
		{addr, rd} <= {x[4:0], 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk($sformatf("reg %0h", x), rdata, exp_rd(x));
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic sweep();
		for (int k = 0; k < 32; k++)
			rd_chk(k);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// --------------------------------
	// clock, watchdog, tests
	// --------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// the whole run needs under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		finish_test();
	end
	initial begin
		rst = 1'b1;
		{wr, rd, rs, qs, man, addr, wdata} = 26'h0;
		{pa, pb, oa, ob} = 64'h0;
		seed = $urandom(32'h676e3347);
		mpk = 16'h0800 + 16'($urandom % 2048);
		ppk = 16'h0600 + 16'($urandom % 2560);
		pnom = ppk >> 1;
		mns = 16'h1000 + 16'($urandom % 4096);
		for (i = 0; i < 32; i++)
			m[i] = 16'h0;
		{m[4], m[8], fca, sel} = {16'h1, 16'h1, 2'h1, 32'd1};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		tick(3);
		chk("chopper reset", {13'h0, oh}, 16'h0002);
		sweep();
		for (i = 0; i < 60; i++) begin
			a = $urandom % 9;
			d = ($urandom % 2) ? ($urandom % 4) : ($urandom % 5120);
			wr_reg(a, d[15:0]);
		end
		tick(4);
		sweep();
		for (i = 0; i < 4; i++) begin
			a = (i < 2) ? i : i + 3;
			wr_reg(a, ilim_max() + 16'h1);
			rd_chk(a);
			wr_reg(a, ilim_max());
			rd_chk(a);
		end
		wr_reg(0, 16'h0100);
		wr_reg(1, 16'h0200);
		wr_reg(5, 16'h0300);
		wr_reg(6, 16'h0400);
		for (i = 0; i < 16; i++) begin
			wr_reg(4, {14'h0, i[3:2]});
			{qs, man} <= i[1:0];
			tick(4);
			chk("current limit", acl, exp_acl());
			chk("set two", {15'h0, s2}, {15'h0, sel == 2});
		end
		// manual limit at the 8 kHz ceiling, so a derated restart clamps it unless the motor peak is still the lower ceiling
		wr_reg(6, ilim_max());
		{qs, man} <= 2'h1;
		for (i = 0; i < 3; i++) begin
			a = (i + 2) % 3;
			wr_reg(8, a[15:0]);
			tick(4);
			chk("chopper held", {13'h0, oh}, 16'h1 << fca);
			rs <= 1'b1;
			@(posedge clk);
			rs <= 1'b0;
			fca = a[1:0];
			tick(4);
			chk("chopper live", {13'h0, oh}, 16'h1 << fca);
			chk("peak current", psp, der(ppk));
			chk("nominal current", psn, der(pnom));
			chk("clamped limit", acl, exp_acl());
			rd_chk(9);
		end
		wr_reg(7, 16'h1);
		tick(2);
		chk("brake flag", {15'h0, brc}, 16'h1);
		wr_reg(7, 16'h2);
		tick(2);
		chk("brake flag", {15'h0, brc}, 16'h1);
		wr_reg(14, 16'h1);
		tick(2);
		chk("mapping", {15'h0, iom}, 16'h1);
		wr_reg(14, 16'h0);
		tick(2);
		chk("mapping", {15'h0, iom}, 16'h0);
		for (i = 16; i < 20; i++)
			wr_reg(i, 16'($urandom));
		for (i = 0; i < 6; i++) begin
			wr_reg(15, {12'h0, 4'(i * 5)});
			{pa, pb, oa, ob} <= {$urandom, $urandom};
			tick(4);
			chk("in a", iwa, exp_rd(10));
			chk("in b", iwb, exp_rd(11));
			chk("out a", owa, exp_rd(12));
			chk("out b", owb, exp_rd(13));
		end
		sweep();
		finish_test();
	end
endmodule // dlpb_bank_tb_top
`default_nettype wire
